// file: hdl/motion_status_window_monitor.sv
// servo status window monitor: zero speed, in-position and speed reached bits
// Summary of operation
// - clear status bit 12 when abs speed stays above level for filter time
// - set bit 10 when position error stays within range for filter time
// - range or filter time of 65535 keeps target reached always on
// - in-position check only in profile position or homing mode
// - position range resets to 100, unit pulses or millidegrees per unit select
// - set velocity reached bit 10 when speed error in window for filter time
// - zero speed and speed reached checks only in profile velocity mode
// - velocity window resets to 20.00 r/min, 0.01 steps up to 655.35
// - filter times count milliseconds, reset to 10, range 0 to 65535
// - position window range accepts 0 to 65535
// - parameters reachable as profile objects 6067h 6068h 606Dh 606Eh 606Fh 6070h
// - cyclic controller value overwrites local tool writes when mapped
// - zero speed level resets to 50.00 r/min, compared to abs speed
`include "motion_window_defines.svh"
module motion_status_window_monitor #(
	parameter int tick_cycles = `TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] operation_mode,
	input wire logic position_unit_selection,
	input wire motion_window_pkg::signed_word_t command_position,
	input wire motion_window_pkg::signed_word_t current_position,
	input wire logic signed [15:0] command_speed,
	input wire logic signed [15:0] motor_speed,
	input wire logic obj_write,
	input wire logic obj_cyclic,
	input wire logic [15:0] obj_index,
	input wire motion_window_pkg::param_t obj_wdata,
	input wire logic obj_read,
	output motion_window_pkg::param_t obj_rdata,
	output logic obj_ack,
	output logic obj_error,
	output logic [15:0] status_word,
	output logic position_unit_degree
);
	import motion_window_pkg::*;

	param_t zero_speed_level;
	param_t zero_speed_filter_time;
	param_t position_window_range;
	param_t position_window_filter_time;
	param_t velocity_window_range;
	param_t velocity_window_filter_time;
	logic [5:0] cyclic_mapped;
	logic [31:0] tick_count;
	logic ms_tick;

	function automatic logic [15:0] abs16(input logic signed [16:0] v);
		logic signed [16:0] a;
		a = (v < 0) ? -v : v;
		return (a > 17'sh0FFFF) ? 16'hFFFF : a[15:0];
	endfunction

	// index decode, shared by write, read and mapping
	function automatic logic [2:0] obj_slot(input logic [15:0] idx);
		case (idx)
			`OBJ_VELOCITY_THRESHOLD: obj_slot = 3'h0;
			`OBJ_VELOCITY_THRESHOLD_TIME: obj_slot = 3'h1;
			`OBJ_POSITION_WINDOW: obj_slot = 3'h2;
			`OBJ_POSITION_WINDOW_TIME: obj_slot = 3'h3;
			`OBJ_VELOCITY_WINDOW: obj_slot = 3'h4;
			`OBJ_VELOCITY_WINDOW_TIME: obj_slot = 3'h5;
			default: obj_slot = 3'h7;
		endcase
	endfunction

	wire [2:0] slot = obj_slot(obj_index);
	wire slot_ok = (slot != 3'h7);
	// mapped objects refuse local tool writes so the controller value stands
	wire local_blocked = slot_ok && !obj_cyclic && cyclic_mapped[slot];
	wire write_ok = obj_write && slot_ok && !local_blocked;
	wire write_bad = obj_write && !write_ok;

	// millisecond time base for every filter timer
	wire tick_wrap = (tick_count == 32'(tick_cycles - 1));

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			tick_count <= 32'h00000000;
			ms_tick <= 1'b0;
		end else begin
			tick_count <= tick_wrap ? 32'h00000000 : tick_count + 32'h00000001;
			ms_tick <= tick_wrap;
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			zero_speed_level <= `RST_ZERO_SPEED_LEVEL;
			zero_speed_filter_time <= `RST_FILTER_TIME;
			position_window_range <= `RST_POSITION_WINDOW;
			position_window_filter_time <= `RST_FILTER_TIME;
			velocity_window_range <= `RST_VELOCITY_WINDOW;
			velocity_window_filter_time <= `RST_FILTER_TIME;
		end else if (write_ok) begin
			// full 16-bit range is legal for every object
			case (slot)
				3'h0: zero_speed_level <= obj_wdata;
				3'h1: zero_speed_filter_time <= obj_wdata;
				3'h2: position_window_range <= obj_wdata;
				3'h3: position_window_filter_time <= obj_wdata;
				3'h4: velocity_window_range <= obj_wdata;
				3'h5: velocity_window_filter_time <= obj_wdata;
				default: ;
			endcase
		end
	end

	// first cyclic write of an object marks it as mapped until reset
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			cyclic_mapped <= 6'h00;
		end else if (write_ok && obj_cyclic) begin
			cyclic_mapped[slot] <= 1'b1;
		end
	end

	param_t read_mux;
	always_comb begin
		case (slot)
			3'h0: read_mux = zero_speed_level;
			3'h1: read_mux = zero_speed_filter_time;
			3'h2: read_mux = position_window_range;
			3'h3: read_mux = position_window_filter_time;
			3'h4: read_mux = velocity_window_range;
			3'h5: read_mux = velocity_window_filter_time;
			default: read_mux = 16'h0000;
		endcase
	end

	link_state_t next_link_state;
	always_comb begin
		case ({obj_write || obj_read, write_bad || (obj_read && !slot_ok)})
			2'b10: next_link_state = link_write;
			2'b11: next_link_state = link_reject;
			default: next_link_state = link_idle;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			obj_rdata <= 16'h0000;
			obj_ack <= 1'b0;
			obj_error <= 1'b0;
		end else begin
			obj_rdata <= obj_read ? read_mux : 16'h0000;
			obj_ack <= (next_link_state == link_write);
			obj_error <= (next_link_state == link_reject);
		end
	end

	// mode qualification
	wire mode_position = (operation_mode == `MODE_PROFILE_POSITION) ||
		(operation_mode == `MODE_HOMING);
	wire mode_velocity = (operation_mode == `MODE_PROFILE_VELOCITY);

	// window comparisons; position error kept at full 33-bit width
	wire signed [32:0] pos_err = 33'(signed'(command_position)) -
		33'(signed'(current_position));
	wire [32:0] pos_abs = pos_err[32] ? 33'(-pos_err) : 33'(pos_err);
	wire pos_in = (pos_abs <= 33'(position_window_range));
	wire speed_above = (abs16(17'(motor_speed)) > zero_speed_level);
	wire vel_in = (abs16(17'(command_speed) - 17'(motor_speed))
		<= velocity_window_range);
	wire pos_always = (position_window_range == `ALWAYS_ON_VALUE) ||
		(position_window_filter_time == `ALWAYS_ON_VALUE);

	logic pos_qual;
	logic moving_qual;
	logic vel_qual;

	window_qualifier u_pos (
		.mclk(mclk),
		.reset_n(reset_n),
		.ms_tick(ms_tick),
		.enable(mode_position),
		.in_window(pos_in),
		.filter_time(position_window_filter_time),
		.qualified(pos_qual)
	);

	window_qualifier u_zero (
		.mclk(mclk),
		.reset_n(reset_n),
		.ms_tick(ms_tick),
		.enable(mode_velocity),
		.in_window(speed_above),
		.filter_time(zero_speed_filter_time),
		.qualified(moving_qual)
	);

	window_qualifier u_vel (
		.mclk(mclk),
		.reset_n(reset_n),
		.ms_tick(ms_tick),
		.enable(mode_velocity),
		.in_window(vel_in),
		.filter_time(velocity_window_filter_time),
		.qualified(vel_qual)
	);

	// bit 10 is shared: target reached or target velocity reached by mode
	wire next_bit10 = (mode_position && (pos_always || pos_qual)) ||
		(mode_velocity && vel_qual);
	// speed bit on in velocity mode until motion qualifies above level
	wire next_bit12 = mode_velocity && !moving_qual;

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			status_word <= 16'h0000;
			position_unit_degree <= 1'b0;
		end else begin
			status_word[`SW_BIT_TARGET_REACHED] <= next_bit10;
			status_word[`SW_BIT_SPEED] <= next_bit12;
			position_unit_degree <= position_unit_selection;
		end
	end
endmodule

// file: hdl/motion_window_defines.svh
// constants for the motion status window monitor
`ifndef MOTION_WINDOW_DEFINES_SVH
`define MOTION_WINDOW_DEFINES_SVH
`define OBJ_POSITION_WINDOW 16'h6067
`define OBJ_POSITION_WINDOW_TIME 16'h6068
`define OBJ_VELOCITY_WINDOW 16'h606D
`define OBJ_VELOCITY_WINDOW_TIME 16'h606E
`define OBJ_VELOCITY_THRESHOLD 16'h606F
`define OBJ_VELOCITY_THRESHOLD_TIME 16'h6070
`define RST_ZERO_SPEED_LEVEL 16'h1388
`define RST_FILTER_TIME 16'h000A
`define RST_POSITION_WINDOW 16'h0064
`define RST_VELOCITY_WINDOW 16'h07D0
`define ALWAYS_ON_VALUE 16'hFFFF
`define SW_BIT_TARGET_REACHED 10
`define SW_BIT_SPEED 12
`define MODE_PROFILE_POSITION 8'h01
`define MODE_PROFILE_VELOCITY 8'h03
`define MODE_HOMING 8'h06
`define TICK_PERIOD_NS 1000000
`define CLK_PERIOD_NS 8
`define TICK_CYCLES (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`endif

// file: hdl/motion_window_pkg.sv
// types for the motion status window monitor
package motion_window_pkg;
	typedef logic [15:0] param_t;
	typedef logic [31:0] signed_word_t;
	typedef enum logic [1:0] {
		link_idle = 2'b00,
		link_write = 2'b01,
		link_reject = 2'b10
	} link_state_t;
endpackage

// file: hdl/window_qualifier.sv
// millisecond filter that qualifies a window condition
module window_qualifier (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic ms_tick,
	input wire logic enable,
	input wire logic in_window,
	input wire logic [15:0] filter_time,
	output logic qualified
);
	logic [15:0] elapsed;
	wire cond = enable && in_window;
	wire reached = (elapsed >= filter_time);

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			elapsed <= 16'h0000;
		end else if (!cond) begin
			elapsed <= 16'h0000;
		end else if (ms_tick && !reached) begin
			elapsed <= elapsed + 16'h0001;
		end
	end

	// drops in the same cycle the condition fails
	assign qualified = cond && reached;
endmodule

// file: verif/motion_window_checker.sv
// port assertions for the window monitor
module motion_window_checker (
	input wire logic mclk,
	input wire logic reset_n,
	input wire logic [7:0] operation_mode,
	input wire logic position_unit_selection,
	input wire logic obj_write,
	input wire logic obj_read,
	input wire motion_window_pkg::param_t obj_rdata,
	input wire logic obj_ack,
	input wire logic obj_error,
	input wire logic [15:0] status_word,
	input wire logic position_unit_degree
);
	timeunit 1ns;
	timeprecision 1ps;
	import motion_window_pkg::*;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	wire req = obj_write || obj_read;
	wire act = operation_mode inside {8'h01, 8'h03, 8'h06};
	a_one_answer: assert property (req |=> obj_ack != obj_error) else $error("no answer");
	a_no_answer: assert property (!req |=> !obj_ack && !obj_error) else $error("stray ack");
	a_rdata_idle: assert property (!obj_read |=> obj_rdata == 16'h0000) else $error("rdata");
	a_unit_copy:
		assert property (1'b1 |=> position_unit_degree == $past(position_unit_selection))
		else $error("unit copy");
	a_mode_gate: assert property (!act |=> status_word == 16'h0000) else $error("gate");
	a_spare_bits: assert property ((status_word & 16'hEBFF) == 16'h0000) else $error("spare");
	a_speed_mode:
		assert property (operation_mode != 8'h03 |=> !status_word[12]) else $error("speed bit");
	a_rise_cause: assert property ($rose(status_word[10]) |-> $past(act)) else $error("rise");
	c_reached: cover property (status_word[10]);
	c_speed: cover property (status_word[12]);
	c_refused: cover property (obj_error);
endmodule
bind motion_status_window_monitor motion_window_checker u_motion_window_checker (.mclk, .reset_n,
	.operation_mode, .position_unit_selection, .obj_write, .obj_read, .obj_rdata, .obj_ack,
	.obj_error, .status_word, .position_unit_degree);

// file: verif/motion_controller_model.sv
// network controller model issuing object accesses
module motion_controller_model (
	output logic obj_write,
	output logic obj_cyclic,
	output logic [15:0] obj_index,
	output logic [15:0] obj_wdata,
	output logic obj_read,
	input wire logic mclk
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		obj_write = 1'b0;
		obj_read = 1'b0;
		obj_cyclic = 1'b0;
		obj_index = 16'h0000;
		obj_wdata = 16'h0000;
	end
	task automatic access(input logic w, input logic c, input logic [15:0] i, input logic [15:0] d);
		@(posedge mclk);
		obj_write <= w;
		obj_read <= !w;
		obj_cyclic <= c;
		obj_index <= i;
		obj_wdata <= d;
		@(posedge mclk);
		obj_write <= 1'b0;
		obj_read <= 1'b0;
		// released lines show junk, not the last value
		obj_index <= ~i;
		obj_wdata <= ~d;
		#1;
	endtask
endmodule

// file: verif/motion_status_window_monitor_bench.sv
// self-checking bench for the window monitor
module motion_status_window_monitor_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import motion_window_pkg::*;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic position_unit_selection = 1'b0;
	logic [7:0] operation_mode = 8'h00;
	signed_word_t command_position = 32'h000003E8;
	signed_word_t current_position = 32'h00000000;
	logic signed [15:0] command_speed = 16'h0000;
	logic signed [15:0] motor_speed = 16'h0000;
	wire logic obj_write, obj_cyclic, obj_read;
	wire logic [15:0] obj_index;
	wire param_t obj_wdata;
	param_t obj_rdata;
	logic obj_ack, obj_error, position_unit_degree;
	logic [15:0] status_word;
	int error_cnt = 0;
	int checks_done = 0;
	int cycles = 0;
	localparam logic [15:0] ri [6] = '{16'h606F, 16'h6070, 16'h6067, 16'h6068, 16'h606D, 16'h606E};
	localparam logic [15:0] rv [6] = '{16'h1388, 16'h000A, 16'h0064, 16'h000A, 16'h07D0, 16'h000A};
	motion_controller_model u_motion_controller_model (.obj_write, .obj_cyclic, .obj_index,
		.obj_wdata, .obj_read, .mclk);
	// short tick keeps 10 ms filters at 40 clocks
	motion_status_window_monitor #(.tick_cycles(4)) u_motion_status_window_monitor (.mclk,
		.reset_n, .operation_mode, .position_unit_selection, .command_position,
		.current_position, .command_speed, .motor_speed, .obj_write, .obj_cyclic, .obj_index,
		.obj_wdata, .obj_read, .obj_rdata, .obj_ack, .obj_error, .status_word,
		.position_unit_degree);
	always #4 mclk = ~mclk;
	always @(posedge mclk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			error_cnt++;
			end_of_test();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic c, input logic [15:0] i, input logic [15:0] d, input logic e);
		u_motion_controller_model.access(1'b1, c, i, d);
		chk({14'h0000, obj_error, obj_ack}, e ? 16'h0002 : 16'h0001);
	endtask
	task automatic rd(input logic [15:0] i, input logic [15:0] d);
		u_motion_controller_model.access(1'b0, 1'b0, i, 16'h0000);
		chk(obj_rdata, d);
	endtask
	task automatic stat(input int n, input logic [15:0] e);
		repeat (n) @(posedge mclk);
		#1;
		chk(status_word, e);
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		for (int k = 0; k < 6; k++) rd(ri[k], rv[k]);
		wr(1'b1, 16'h6069, 16'h0001, 1'b1);
		wr(1'b1, 16'h6067, 16'h0005, 1'b0);
		wr(1'b0, 16'h6067, 16'h0007, 1'b1);
		rd(16'h6067, 16'h0005);
		$display("object test done");
		@(posedge mclk);
		operation_mode <= 8'h01;
		stat(29, 16'h0000);
		wr(1'b1, 16'h6068, 16'hFFFF, 1'b0);
		stat(3, 16'h0400);
		wr(1'b1, 16'h6068, 16'h0002, 1'b0);
		@(posedge mclk);
		current_position <= 32'h000003E3;
		stat(2, 16'h0000);
		stat(12, 16'h0400);
		@(posedge mclk);
		current_position <= 32'h000003E2;
		stat(1, 16'h0000);
		@(posedge mclk);
		operation_mode <= 8'h06;
		current_position <= 32'h000003E3;
		stat(14, 16'h0400);
		wr(1'b1, 16'h6067, 16'hFFFF, 1'b0);
		@(posedge mclk);
		current_position <= 32'h00000000;
		stat(2, 16'h0400);
		@(posedge mclk);
		operation_mode <= 8'h00;
		position_unit_selection <= 1'b1;
		stat(1, 16'h0000);
		chk({15'h0000, position_unit_degree}, 16'h0001);
		$display("position test done");
		@(posedge mclk);
		operation_mode <= 8'h03;
		command_speed <= 16'hE890;
		motor_speed <= 16'hE890;
		stat(19, 16'h1000);
		stat(40, 16'h0400);
		@(posedge mclk);
		motor_speed <= 16'hF060;
		stat(1, 16'h1400);
		@(posedge mclk);
		motor_speed <= 16'hF061;
		stat(1, 16'h1000);
		$display("velocity test done");
		end_of_test();
	end
endmodule
